// >>> verilog/ssac_pkg.sv
// Package for the serial step angle control block.
// Assumes one 200 MHz clock domain and a synchronous reset.
package ssac_pkg;
  localparam int          ANGLE_W     = 6;
  localparam logic [5:0]  ANGLE_RST   = 6'h00;
  localparam int          SHIFT_W     = 16;
  localparam logic [15:0] SHIFT_RST   = 16'h0000;
  localparam int          ADDR_W      = 2;
  localparam logic [1:0]  RUN_ADDR    = 2'h3;
  localparam int          CHG_LSB     = 0;
  localparam int          CHG_W       = 6;
  localparam logic [5:0]  FULL_OFFSET = 6'h08;
  localparam logic [5:0]  STEP_FULL   = 6'h10;
  localparam logic [5:0]  STEP_HALF   = 6'h08;
  localparam logic [5:0]  STEP_QUART  = 6'h04;
  localparam logic [5:0]  STEP_EIGHTH = 6'h02;

  typedef enum logic [3:0] {
    RES_FULL    = 4'b0001,
    RES_HALF    = 4'b0010,
    RES_QUARTER = 4'b0100,
    RES_EIGHTH  = 4'b1000
  } ssac_res_t;
endpackage

// >>> verilog/ssac_sync_if.sv
// Interface between the top module and one pin synchroniser.
// Assumes the owner drives raw from a pin outside the clock domain.
`timescale 1ns/1ps
interface ssac_sync_if;
  logic raw;
  logic level;
  logic rise;
  modport sync (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface

// >>> verilog/ssac_edge_sync.sv
// Two-flop synchroniser with rising edge detect for one pin.
// Assumes CLK is much faster than the pin toggles.
`timescale 1ns/1ps
module ssac_edge_sync
  import ssac_pkg::*;
#(
  parameter logic IDLE = 1'b0
)
(
  input  wire logic  CLK,
  input  wire logic  RESET,
  ssac_sync_if.sync  port
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  always_comb
  begin
    meta_next = port.raw;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  // Reset to idle level so release makes no false edge
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      meta_reg <= IDLE;
      sync_reg <= IDLE;
      last_reg <= IDLE;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign port.level = sync_reg;
  assign port.rise  = sync_reg & ~last_reg;
endmodule

// >>> verilog/ssac_top.sv
// Step angle number logic: serial step changes and step/direction translator.
// Assumes all pins come from outside the CLK domain; RES_CFG is from local logic.
`timescale 1ns/1ps
module ssac_top
  import ssac_pkg::*;
(
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire logic         SCK,
  input  wire logic         SDI,
  input  wire logic         SERIAL_STROBE_N,
  input  wire logic         STEP_IN,
  input  wire logic         DIR_IN,
  input  wire logic         RESOLUTION_SELECT_IN,
  input  wire logic [1:0]   RES_CFG,
  output logic [5:0]        STEP_ANGLE,
  output logic              MOVE_FWD,
  output logic              MOVE_REV
);
  ssac_sync_if sck_if ();
  ssac_sync_if sdi_if ();
  ssac_sync_if strb_if ();
  ssac_sync_if step_if ();
  ssac_sync_if dir_if ();
  ssac_sync_if ms_if ();

  assign sck_if.raw  = SCK;
  assign sdi_if.raw  = SDI;
  assign strb_if.raw = SERIAL_STROBE_N;
  assign step_if.raw = STEP_IN;
  assign dir_if.raw  = DIR_IN;
  assign ms_if.raw   = RESOLUTION_SELECT_IN;

  // Equal latency keeps SDI aligned with its SCK edge
  ssac_edge_sync #(.IDLE(1'b0)) u_sck  (.CLK(CLK), .RESET(RESET), .port(sck_if));
  ssac_edge_sync #(.IDLE(1'b0)) u_sdi  (.CLK(CLK), .RESET(RESET), .port(sdi_if));
  ssac_edge_sync #(.IDLE(1'b1)) u_strb (.CLK(CLK), .RESET(RESET), .port(strb_if));
  ssac_edge_sync #(.IDLE(1'b0)) u_step (.CLK(CLK), .RESET(RESET), .port(step_if));
  ssac_edge_sync #(.IDLE(1'b0)) u_dir  (.CLK(CLK), .RESET(RESET), .port(dir_if));
  ssac_edge_sync #(.IDLE(1'b0)) u_ms   (.CLK(CLK), .RESET(RESET), .port(ms_if));

  logic [SHIFT_W-1:0] shift_reg;
  logic [SHIFT_W-1:0] shift_next;
  logic [5:0]         angle_reg;
  logic [5:0]         angle_next;
  logic               fwd_reg;
  logic               fwd_next;
  logic               rev_reg;
  logic               rev_next;
  logic               run_hit;
  logic [CHG_W-1:0]   chg;
  ssac_res_t          res;
  logic [5:0]         step_k;
  logic [5:0]         offset;
  logic [5:0]         base;
  logic [5:0]         aligned;
  logic [5:0]         trans_angle;

  // Serial clock only shifts; never touches the angle
  always_comb
  begin
    shift_next = shift_reg;
    if (sck_if.rise)
      shift_next = {shift_reg[SHIFT_W-2:0], sdi_if.level};
  end

  assign run_hit = strb_if.rise && (shift_reg[SHIFT_W-1 -: ADDR_W] == RUN_ADDR);
  assign chg     = shift_reg[CHG_LSB +: CHG_W];

  // Resolution from config bits and pin level
  always_comb
  begin
    case ({RES_CFG, ms_if.level})
      3'b000:  res = RES_HALF;
      3'b001:  res = RES_QUARTER;
      3'b010:  res = RES_FULL;
      3'b011:  res = RES_HALF;
      3'b100:  res = RES_FULL;
      3'b101:  res = RES_QUARTER;
      3'b110:  res = RES_HALF;
      3'b111:  res = RES_EIGHTH;
      default: res = RES_HALF;
    endcase
  end

  always_comb
  begin
    offset = 6'h00;
    case (res)
      RES_FULL:
      begin
        step_k = STEP_FULL;
        offset = FULL_OFFSET;
      end
      RES_HALF:    step_k = STEP_HALF;
      RES_QUARTER: step_k = STEP_QUART;
      RES_EIGHTH:  step_k = STEP_EIGHTH;
      default:     step_k = STEP_HALF;
    endcase
  end

  // Snap to the grid, so a resolution change lands on the next legal number
  always_comb
  begin
    base    = 6'(angle_reg - offset);
    aligned = base & ~6'(step_k - 6'h01);
    if (dir_if.level)
      trans_angle = 6'(aligned + step_k + offset);
    else if (base == aligned)
      trans_angle = 6'(aligned - step_k + offset);
    else
      trans_angle = 6'(aligned + offset);
  end

  // Serial write wins over a STEP edge in the same cycle
  always_comb
  begin
    angle_next = angle_reg;
    fwd_next   = 1'b0;
    rev_next   = 1'b0;
    if (run_hit)
    begin
      angle_next = 6'(angle_reg + chg);
      fwd_next   = !chg[CHG_W-1] && (chg != 6'h00);
      rev_next   = chg[CHG_W-1];
    end
    else if (step_if.rise)
    begin
      angle_next = trans_angle;
      fwd_next   = dir_if.level;
      rev_next   = !dir_if.level;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      shift_reg <= SHIFT_RST;
      angle_reg <= ANGLE_RST;
      fwd_reg   <= 1'b0;
      rev_reg   <= 1'b0;
    end
    else
    begin
      shift_reg <= shift_next;
      angle_reg <= angle_next;
      fwd_reg   <= fwd_next;
      rev_reg   <= rev_next;
    end
  end

  assign STEP_ANGLE = angle_reg;
  assign MOVE_FWD   = fwd_reg;
  assign MOVE_REV   = rev_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  serial_add_a: assert property (run_hit |=> angle_reg == 6'($past(angle_reg) + $past(chg)))
    else $error("Serial step change not applied");
  change_field_a: assert property (strb_if.rise && shift_reg[15:14] == 2'h3 ##1 1'b1
      |-> angle_reg == 6'($past(angle_reg) + $past(shift_reg[5:0])))
    else $error("Step change not from low six bits");
  ms_ignored_a: assert property (run_hit && res != RES_EIGHTH |=> angle_reg == 6'($past(angle_reg) + $past(chg)))
    else $error("Resolution affected serial change");
  strobe_only_a: assert property (!run_hit && !step_if.rise |=> $stable(angle_reg))
    else $error("Angle changed without strobe or step");
  sck_no_step_a: assert property (sck_if.rise && !strb_if.rise && !step_if.rise |=> $stable(angle_reg))
    else $error("Serial clock moved the angle");
  fwd_move_a: assert property (run_hit && !chg[5] && chg != 6'h00 |=> MOVE_FWD && !MOVE_REV ##1 !MOVE_FWD)
    else $error("Forward move not flagged once");
  rev_move_a: assert property (run_hit && chg[5] |=> MOVE_REV && !MOVE_FWD)
    else $error("Reverse move not flagged");
  full_half_a: assert property (step_if.rise && !run_hit && res inside {RES_FULL, RES_HALF}
      |=> angle_reg[2:0] == 3'h0 && ($past(res) != RES_FULL || angle_reg[3] == 1'b1))
    else $error("Full or half step off grid");
  quarter_eighth_a: assert property (step_if.rise && !run_hit && res inside {RES_QUARTER, RES_EIGHTH}
      |=> angle_reg[0] == 1'b0 && ($past(res) != RES_QUARTER || angle_reg[1] == 1'b0))
    else $error("Quarter or eighth step off grid");
  eighth_two_a: assert property (step_if.rise && !run_hit && res == RES_EIGHTH && !angle_reg[0]
      |=> angle_reg == ($past(dir_if.level) ? 6'($past(angle_reg) + 6'h02) : 6'($past(angle_reg) - 6'h02)))
    else $error("Eighth step not two");

  // Grid step size per resolution, from an on-grid start
  full_sixteen_a: assert property (step_if.rise && !run_hit && res == RES_FULL && angle_reg[3:0] == 4'h8
      |=> angle_reg == ($past(dir_if.level) ? 6'($past(angle_reg) + STEP_FULL) : 6'($past(angle_reg) - STEP_FULL)))
    else $error("Full step not sixteen");
  half_eight_a: assert property (step_if.rise && !run_hit && res == RES_HALF && angle_reg[2:0] == 3'h0
      |=> angle_reg == ($past(dir_if.level) ? 6'($past(angle_reg) + STEP_HALF) : 6'($past(angle_reg) - STEP_HALF)))
    else $error("Half step not eight");
  quart_four_a: assert property (step_if.rise && !run_hit && res == RES_QUARTER && angle_reg[1:0] == 2'h0
      |=> angle_reg == ($past(dir_if.level) ? 6'($past(angle_reg) + STEP_QUART) : 6'($past(angle_reg) - STEP_QUART)))
    else $error("Quarter step not four");
  step_dir_a: assert property (step_if.rise && !run_hit
      |=> MOVE_FWD == $past(dir_if.level) && MOVE_REV != $past(dir_if.level))
    else $error("Step move flag wrong");
  move_excl_a: assert property (!(MOVE_FWD && MOVE_REV))
    else $error("Both move flags set");
  serial_zero_a: assert property (run_hit && chg == 6'h00 |=> !MOVE_FWD && !MOVE_REV)
    else $error("Zero change flagged a move");

  wrap_fwd_c: cover property (run_hit && angle_reg == 6'h3F && chg == 6'h01 ##1 angle_reg == 6'h00);
  serial_rev_c: cover property (run_hit && chg == 6'h3C);
  eighth_c: cover property (step_if.rise && !run_hit && res == RES_EIGHTH);
  full_c: cover property (step_if.rise && !run_hit && res == RES_FULL ##1 angle_reg == 6'h08);
endmodule

// >>> verif/ssac_host_model.sv
// Host model: shifts a 16-bit word out on the serial pins and ends it with a strobe rise when rise is set.
// Assumes the bench clock CLK; pins change only after its falling edge.
`timescale 1ns/1ps
module ssac_host_model
(
  input  wire logic CLK,
  output logic      SCK,
  output logic      SDI,
  output logic      SERIAL_STROBE_N
);
  initial
  begin
    SCK = 1'b0;
    SDI = 1'b0;
    SERIAL_STROBE_N = 1'b1;
  end

  // Caller packs the other run bits into every word it sends
  task automatic send(input logic [15:0] word, input bit rise);
    @(negedge CLK);
    SERIAL_STROBE_N = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      SDI = word[i];
      // Link clock of 125 ns, all inside the strobe-low frame
      repeat (12) @(negedge CLK);
      SCK = 1'b1;
      repeat (13) @(negedge CLK);
      SCK = 1'b0;
    end
    // Released data line shows the inverse, not a stale bit
    SDI = ~word[0];
    repeat (4) @(negedge CLK);
    if (rise)
      SERIAL_STROBE_N = 1'b1;
  endtask
endmodule

// >>> verif/ssac_top_bench.sv
// Bench for ssac_top: integer angle model checked after every serial write and step.
// Assumes ssac_host_model on the serial pins; the bench drives the step pins.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %0d got %0d", nm, e, g); end end
module ssac_top_bench;
  import ssac_pkg::*;
  logic        clk, reset, sck, sdi, strobe_n, step_in, dir_in, res_pin, fwd, rev;
  logic [1:0]  res_cfg;
  logic [5:0]  angle;
  int          failures, checks_done, cycles, fwd_seen, rev_seen, ang;
  logic [31:0] seed = 32'h0000_492f;
  int          ktab [8] = '{8, 4, 16, 8, 16, 4, 8, 2};
  logic [5:0]  tab [11] = '{6'h3F, 6'h01, 6'h10, 6'h30, 6'h08, 6'h38, 6'h04, 6'h3C, 6'h02, 6'h3E, 6'h00};

  ssac_top ssac_top_inst (.CLK(clk), .RESET(reset), .SCK(sck), .SDI(sdi), .SERIAL_STROBE_N(strobe_n),
    .STEP_IN(step_in), .DIR_IN(dir_in), .RESOLUTION_SELECT_IN(res_pin), .RES_CFG(res_cfg),
    .STEP_ANGLE(angle), .MOVE_FWD(fwd), .MOVE_REV(rev));
  ssac_host_model ssac_host_model_inst (.CLK(clk), .SCK(sck), .SDI(sdi), .SERIAL_STROBE_N(strobe_n));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task check(bit ef, bit er);
    `CHK("angle", 6'(ang), angle)
    `CHK("fwd pulses", int'(ef), fwd_seen)
    `CHK("rev pulses", int'(er), rev_seen)
    fwd_seen = 0;
    rev_seen = 0;
  endtask

  task serial(logic [5:0] chg, logic [1:0] addr);
    logic [31:0] r;
    r = rnd();
    // Random resolution must have no say on serial changes
    {res_cfg, res_pin} = r[10:8];
    ssac_host_model_inst.send({addr, r[7:0], chg}, 1'b1);
    repeat (8) @(negedge clk);
    if (addr == RUN_ADDR)
      ang = (ang + int'($signed(chg)) + 64) % 64;
    check(addr == RUN_ADDR && chg != 0 && !chg[5], addr == RUN_ADDR && chg[5]);
  endtask

  task step(bit d);
    int k, o, r;
    dir_in = d;
    repeat (4) @(negedge clk);
    step_in = 1'b1;
    repeat (6) @(negedge clk);
    step_in = 1'b0;
    repeat (6) @(negedge clk);
    k = ktab[{res_cfg, res_pin}];
    o = (k == 16) ? 8 : 0;
    r = (ang - o + 64) % 64;
    r = d ? (r / k + 1) * k : ((r % k == 0) ? r - k : r - r % k);
    ang = (r + o + 64) % 64;
    check(d, !d);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Sampled mid-cycle, where the registered pulses have settled; unknown counts as a pulse
  always @(negedge clk)
  begin
    cycles++;
    fwd_seen += (fwd !== 1'b0);
    rev_seen += (rev !== 1'b0);
    // About 17k cycles expected; over double margin
    if (cycles == 40000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    {reset, step_in, dir_in, res_pin, res_cfg} = 6'h20;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    check(0, 0);
    foreach (tab[i]) serial(tab[i], RUN_ADDR);
    repeat (24) serial(6'(rnd()), RUN_ADDR);
    for (int a = 0; a < 3; a++) serial(6'h05, 2'(a));
    ssac_host_model_inst.send(16'hC005, 1'b0);
    repeat (8) @(negedge clk);
    check(0, 0);
    $display("test serial done");
    if (ang % 2)
      serial(6'h01, RUN_ADDR);
    for (int m = 7; m >= 0; m--)
    begin
      {res_cfg, res_pin} = 3'(m);
      repeat (6) step(1'(rnd() >> 7));
    end
    $display("test step done");
    give_verdict();
  end
endmodule
